// ===== hfd_top.sv
// Module: Hall filter, delay path and commutation decoder with APB registers
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module hfd_top #(
    parameter int PRE_W = 7
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [hfd_pkg::AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] sensor_pin,
    input wire logic [2:0] comparator_out,
    input wire logic [2:0] timer_cmpa_match,
    output logic [2:0] timer_run_bit,
    output logic [2:0] timer_hw_own,
    output logic [5:0] commutation_entry,
    output logic [2:0] edge_irq,
    output logic [2:0] filtered_sensor
);
    import hfd_pkg::*;

    logic rst_s1_r;
    logic rst_s_r;
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    logic [2:0] cmp_s1_r;
    logic [2:0] cmp_s2_r;
    logic [7:0] decoder_control_reg_r;
    logic [2:0] soft_hall_reg_r;
    logic [6:0] source_edge_reg_r;
    logic [4:0] filter_count_reg_r;
    logic [3:0] filter_mode_reg_r;
    logic [5:0] tbl_r [TBL_N];
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [2:0] fprev_r;
    logic [2:0] delay_buffer_first_r;
    logic [2:0] delay_buffer_second_r;
    logic [2:0] tmr_run_r;
    logic [2:0] tmr_own_r;
    logic [5:0] drv_r;
    logic [2:0] irq_r;
    logic [2:0] filt;
    logic [2:0] hall_dly;
    logic [2:0] dec_in;
    logic [3:0] dec_res;
    logic [3:0] entry;
    logic [5:0] sel_entry;
    logic [31:0] rd_data;
    logic rd_err;
    logic wr_go;
    logic dly_on;
    logic [1:0] tsel;

    hfd_filt_if fif ();

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [2:0] tmr_onehot(input logic [1:0] s);
        tmr_onehot = (s == 2'h3) ? 3'h0 : 3'(3'h1 << s);
    endfunction : tmr_onehot

    function automatic logic edge_hit(input logic [1:0] m, input logic p, input logic c);
        edge_hit = ((m == EDGE_RISE) && !p && c)
            || ((m == EDGE_FALL) && p && !c)
            || ((m == EDGE_BOTH) && (p != c));
    endfunction : edge_hit

    // Returns {valid, index}; code is {A, B, C}
    function automatic logic [3:0] hall_index(input logic [2:0] c, input logic a120);
        hall_index = 4'h0;
        unique case (c)
            3'h4: hall_index = 4'h8;
            3'h6: hall_index = 4'h9;
            3'h7: hall_index = a120 ? 4'h0 : 4'hA;
            3'h2: hall_index = a120 ? 4'hA : 4'h0;
            3'h3: hall_index = 4'hB;
            3'h1: hall_index = 4'hC;
            3'h0: hall_index = a120 ? 4'h0 : 4'hD;
            3'h5: hall_index = a120 ? 4'hD : 4'h0;
        endcase
    endfunction : hall_index

    // ************************************************************
    // Reset release and input synchronisers
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_s_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s_r <= rst_s1_r;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_s_r) begin
        if (!rst_s_r) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            cmp_s1_r <= '0;
            cmp_s2_r <= '0;
        end else if (ce) begin
            pin_s1_r <= sensor_pin;
            pin_s2_r <= pin_s1_r;
            cmp_s1_r <= comparator_out;
            cmp_s2_r <= cmp_s1_r;
        end
    end

    // ************************************************************
    // Noise filter
    // ************************************************************
    assign fif.raw = source_edge_reg_r[B_HSEL] ? cmp_s2_r : pin_s2_r;
    assign fif.en = filter_mode_reg_r[B_FEN];
    assign fif.rate = filter_mode_reg_r[2:0];
    assign fif.chk = filter_count_reg_r;
    assign filt = fif.filt;

    hfd_filter #(.PRE_W(PRE_W)) hfd_filter_inst (
        .clk_sys(clk_sys),
        .rst_n(rst_s_r),
        .ce(ce),
        .f(fif.flt)
    );

    // ************************************************************
    // APB slave
    // ************************************************************
    always_comb begin
        rd_data = RD_ZERO;
        rd_err = 1'b0;
        if (paddr[1:0] != 2'h0) begin
            rd_err = 1'b1;
        end else if (paddr == OFS_CTRL) begin
            rd_data[7:0] = decoder_control_reg_r;
        end else if (paddr == OFS_SOFT) begin
            rd_data[2:0] = soft_hall_reg_r;
        end else if (paddr == OFS_EDGE) begin
            rd_data[6:0] = source_edge_reg_r;
        end else if (paddr == OFS_FCNT) begin
            rd_data[4:0] = filter_count_reg_r;
        end else if (paddr == OFS_FMODE) begin
            rd_data[3:0] = filter_mode_reg_r;
        end else if (paddr == OFS_STAT) begin
            rd_data[5:0] = {hall_dly, filt};
        end else if ((paddr >= OFS_TBL) && (paddr[7:2] < OFS_TBL[7:2] + 6'(TBL_N))) begin
            rd_data[5:0] = tbl_r[4'(paddr[7:2] - OFS_TBL[7:2])];
        end else begin
            rd_err = 1'b1;
        end
    end

    assign wr_go = psel && penable && pready_r && pwrite && !pslverr_r;

    always_ff @(posedge clk_sys or negedge rst_s_r) begin
        if (!rst_s_r) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= RD_ZERO;
        end else if (ce) begin
            pready_r <= psel && !penable && !pready_r;
            if (psel && !penable) begin
                pslverr_r <= rd_err;
                prdata_r <= pwrite ? RD_ZERO : rd_data;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_s_r) begin
        if (!rst_s_r) begin
            decoder_control_reg_r <= RST_CTRL;
            soft_hall_reg_r <= '0;
            source_edge_reg_r <= '0;
            filter_count_reg_r <= '0;
            filter_mode_reg_r <= '0;
            for (int i = 0; i < TBL_N; i++) tbl_r[i] <= DRV_OFF;
        end else if (ce && wr_go) begin
            if (paddr == OFS_CTRL) decoder_control_reg_r <= pwdata[7:0];
            if (paddr == OFS_SOFT) soft_hall_reg_r <= pwdata[2:0];
            if (paddr == OFS_EDGE) source_edge_reg_r <= pwdata[6:0];
            if (paddr == OFS_FCNT) filter_count_reg_r <= pwdata[4:0];
            if (paddr == OFS_FMODE) filter_mode_reg_r <= pwdata[3:0];
            for (int i = 0; i < TBL_N; i++) begin
                if (paddr[7:2] == OFS_TBL[7:2] + 6'(i)) tbl_r[i] <= pwdata[5:0];
            end
        end
    end

    // ************************************************************
    // Delay path
    // ************************************************************
    assign dly_on = decoder_control_reg_r[B_DLY];
    assign tsel = decoder_control_reg_r[B_TSEL+:2];

    always_ff @(posedge clk_sys or negedge rst_s_r) begin
        if (!rst_s_r) begin
            fprev_r <= '0;
            delay_buffer_first_r <= '0;
            delay_buffer_second_r <= '0;
            tmr_run_r <= '0;
            tmr_own_r <= '0;
        end else if (ce) begin
            fprev_r <= filt;
            if (!dly_on) begin
                delay_buffer_first_r <= '0;
                delay_buffer_second_r <= '0;
                tmr_run_r <= '0;
                tmr_own_r <= '0;
            end else begin
                tmr_own_r <= tmr_onehot(tsel);
                if (filt != fprev_r) begin
                    delay_buffer_first_r <= filt;
                    tmr_run_r <= tmr_onehot(tsel);
                end else if (|(tmr_run_r & timer_cmpa_match)) begin
                    delay_buffer_second_r <= delay_buffer_first_r;
                    tmr_run_r <= '0;
                end
            end
        end
    end

    assign hall_dly = dly_on ? delay_buffer_second_r : filt;

    // ************************************************************
    // Edge events
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_s_r) begin
        if (!rst_s_r) begin
            irq_r <= '0;
        end else if (ce) begin
            for (int i = 0; i < 3; i++) begin
                irq_r[i] <= edge_hit(source_edge_reg_r[2*i+:2], fprev_r[i], filt[i]);
            end
        end
    end

    // ************************************************************
    // Commutation decoder
    // ************************************************************
    assign dec_in = decoder_control_reg_r[B_IMODE] ? hall_dly : soft_hall_reg_r;
    assign dec_res = hall_index({dec_in[0], dec_in[1], dec_in[2]}, decoder_control_reg_r[B_ANGLE]);
    assign entry = {1'b0, dec_res[2:0]} + (decoder_control_reg_r[B_DIR] ? TBL_BWD : 4'h0);
    assign sel_entry = tbl_r[entry];

    always_ff @(posedge clk_sys or negedge rst_s_r) begin
        if (!rst_s_r) begin
            drv_r <= DRV_OFF;
        end else if (ce) begin
            if (decoder_control_reg_r[B_BRAKE]) begin
                drv_r <= DRV_BRAKE;
            end else if (!dec_res[3]) begin
                drv_r <= DRV_OFF;
            end else if (!decoder_control_reg_r[B_DEC_EN]) begin
                drv_r <= DRV_OFF;
            end else begin
                drv_r <= sel_entry;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign timer_run_bit = tmr_run_r;
    assign timer_hw_own = tmr_own_r;
    assign commutation_entry = drv_r;
    assign edge_irq = irq_r;
    assign filtered_sensor = filt;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_s_r);

    chk_brake_out: assert property (ce && decoder_control_reg_r[B_BRAKE] |=> drv_r == DRV_BRAKE)
        else $error("brake pattern missing");
    chk_free_run: assert property (ce && !decoder_control_reg_r[B_BRAKE]
        && !decoder_control_reg_r[B_DEC_EN] |=> drv_r == DRV_OFF)
        else $error("disabled decoder drove outputs");
    chk_invalid_code: assert property (ce && !decoder_control_reg_r[B_BRAKE]
        && !dec_res[3] |=> drv_r == DRV_OFF)
        else $error("invalid code drove outputs");
    chk_fwd_entry: assert property (ce && decoder_control_reg_r[2:0] == 3'h1 && dec_res[3]
        |=> drv_r == tbl_r[$past(dec_res[2:0])])
        else $error("forward entry mismatch");
    chk_bwd_entry: assert property (ce && decoder_control_reg_r[2:0] == 3'h3 && dec_res[3]
        |=> drv_r == tbl_r[$past(dec_res[2:0]) + 4'h6])
        else $error("backward entry mismatch");
    chk_buf_clear: assert property (ce && !dly_on |=> delay_buffer_first_r == 3'h0
        && delay_buffer_second_r == 3'h0)
        else $error("delay buffers not cleared");
    chk_timer_free: assert property (ce && !dly_on |=> tmr_run_r == 3'h0 && tmr_own_r == 3'h0)
        else $error("timer touched while delay off");
    chk_timer_own: assert property (ce && dly_on |=> tmr_own_r == tmr_onehot($past(tsel)))
        else $error("wrong timer dedicated");
    chk_irq_c_rise: assert property (ce && source_edge_reg_r[5:4] == EDGE_RISE
        && !fprev_r[2] && filt[2] |=> irq_r[2])
        else $error("channel C rise lost");
    chk_irq_b_fall: assert property (ce && source_edge_reg_r[3:2] == EDGE_FALL
        && fprev_r[1] && !filt[1] |=> irq_r[1])
        else $error("channel B fall lost");
    chk_irq_a_off: assert property (ce && source_edge_reg_r[1:0] == EDGE_OFF |=> !irq_r[0])
        else $error("channel A event while disabled");

    cov_brake: cover property (ce && decoder_control_reg_r[B_BRAKE] ##1 drv_r == DRV_BRAKE);
    cov_forward: cover property (ce && decoder_control_reg_r[2:0] == 3'h1 && dec_res[3]);
    cov_delay_match: cover property (|(tmr_run_r & timer_cmpa_match) && dly_on);
    cov_irq: cover property (|irq_r);
endmodule : hfd_top
`default_nettype wire

// ===== hfd_pkg.sv
// Package: register map, field positions and codes of the Hall front end
`default_nettype none
package hfd_pkg;
    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam int unsigned AW = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SOFT = 8'h04;
    localparam logic [7:0] OFS_EDGE = 8'h08;
    localparam logic [7:0] OFS_FCNT = 8'h0C;
    localparam logic [7:0] OFS_FMODE = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;
    localparam logic [7:0] OFS_TBL = 8'h20;
    localparam int unsigned TBL_N = 12;
    localparam logic [3:0] TBL_BWD = 4'h6;
    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int B_DEC_EN = 0;
    localparam int B_DIR = 1;
    localparam int B_BRAKE = 2;
    localparam int B_IMODE = 3;
    localparam int B_ANGLE = 4;
    localparam int B_DLY = 5;
    localparam int B_TSEL = 6;
    localparam int B_HSEL = 6;
    localparam int B_FEN = 3;
    localparam logic [7:0] RST_CTRL = 8'h10;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    // ************************************************************
    // Codes
    // ************************************************************
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [2:0] RATE_UNUSED = 3'h7;
    localparam logic [5:0] DRV_BRAKE = 6'h15;
    localparam logic [5:0] DRV_OFF = 6'h00;
endpackage : hfd_pkg
`default_nettype wire

// ===== hfd_filt_if.sv
// Interface: configuration and data between core and noise filter
`timescale 1ns/1ns
`default_nettype none
interface hfd_filt_if;
    logic [2:0] raw;
    logic en;
    logic [2:0] rate;
    logic [4:0] chk;
    logic [2:0] filt;
    modport ctl (output raw, en, rate, chk, input filt);
    modport flt (input raw, en, rate, chk, output filt);
endinterface : hfd_filt_if
`default_nettype wire

// ===== hfd_filter.sv
// Module: sampling noise filter for the three Hall channels
`timescale 1ns/1ns
`default_nettype none
module hfd_filter #(
    parameter int PRE_W = 7
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    hfd_filt_if.flt f
);
    import hfd_pkg::*;

    logic [PRE_W-1:0] pre_r;
    logic [4:0] cnt_r [3];
    logic [2:0] out_r;
    logic tick;

    if (PRE_W < 7) begin : g_chk
        $error("PRE_W too small for divide by 128");
    end

    function automatic logic [PRE_W-1:0] div_last(input logic [2:0] s);
        logic [2:0] e;
        e = (s == RATE_UNUSED) ? 3'h6 : s;
        div_last = PRE_W'((32'h0000_0002 << e) - 32'h0000_0001);
    endfunction : div_last

    // ************************************************************
    // Sample rate prescaler
    // ************************************************************
    assign tick = (pre_r >= div_last(f.rate));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pre_r <= '0;
        end else if (ce) begin
            pre_r <= tick ? '0 : pre_r + 1'b1;
        end
    end

    // ************************************************************
    // Per channel check counters
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            out_r <= '0;
            for (int i = 0; i < 3; i++) cnt_r[i] <= '0;
        end else if (ce) begin
            for (int i = 0; i < 3; i++) begin
                if (!f.en) begin
                    out_r[i] <= f.raw[i];
                    cnt_r[i] <= '0;
                end else if (tick) begin
                    if (f.raw[i] == out_r[i]) begin
                        cnt_r[i] <= '0;
                    end else if (cnt_r[i] >= f.chk) begin
                        out_r[i] <= f.raw[i];
                        cnt_r[i] <= '0;
                    end else begin
                        cnt_r[i] <= cnt_r[i] + 5'h01;
                    end
                end
            end
        end
    end

    assign f.filt = out_r;

    // ************************************************************
    // Checks
    // ************************************************************
    chk_filter_bypass: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce && !f.en |=> out_r == $past(f.raw))
        else $error("bypass did not pass raw input");
    chk_sample_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce && f.en && !tick |=> out_r == $past(out_r))
        else $error("filter output moved between samples");
    chk_count_accept: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce && f.en && tick && f.chk == 5'h00 |=> out_r == $past(f.raw))
        else $error("zero check count did not accept at once");
endmodule : hfd_filter
`default_nettype wire

// ===== hfd_hall_model.sv
// Partner model: Hall sensors, comparators and delay timers
`timescale 1ns/1ns
`default_nettype none
module hfd_hall_model #(
    parameter int DLY = 20
) (
    input wire logic clk_sys,
    input wire logic [2:0] timer_run_bit,
    output logic [2:0] sensor_pin,
    output logic [2:0] comparator_out,
    output logic [2:0] timer_cmpa_match
);
    logic [7:0] cnt_r [3];
    initial begin
        sensor_pin = 3'h0;
        comparator_out = 3'h0;
        timer_cmpa_match = 3'h0;
        cnt_r = '{8'h00, 8'h00, 8'h00};
    end
    task automatic drive(input logic [2:0] pins, input logic [2:0] cmp);
        @(posedge clk_sys);
        sensor_pin <= pins;
        comparator_out <= cmp;
    endtask : drive
    // ****
    // Timers in compare mode, cleared on match
    // ****
    always @(posedge clk_sys) begin
        for (int i = 0; i < 3; i++) begin
            cnt_r[i] <= (timer_run_bit[i] && cnt_r[i] != 8'(DLY)) ? cnt_r[i] + 8'h01 : 8'h00;
            timer_cmpa_match[i] <= timer_run_bit[i] && cnt_r[i] == 8'(DLY);
        end
    end
endmodule : hfd_hall_model
`default_nettype wire

// ===== tb_hall_filter_delay_commutation.sv
// Testbench: Hall filter, delay path and commutation decoder
`timescale 1ns/1ns
`default_nettype none
module tb_hall_filter_delay_commutation;
    import hfd_pkg::*;
    localparam logic [2:0] SEQ [2][6] = '{'{3'h4, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0},
                                          '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5}};
    localparam logic [2:0] INV [2][2] = '{'{3'h5, 3'h2}, '{3'h7, 3'h0}};
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] sensor_pin;
    logic [2:0] comparator_out;
    logic [2:0] timer_cmpa_match;
    logic [2:0] timer_run_bit;
    logic [2:0] timer_hw_own;
    logic [5:0] commutation_entry;
    logic [2:0] edge_irq;
    logic [2:0] filtered_sensor;
    logic [31:0] rd;
    logic er;
    int fails = 0;
    int checks_done = 0;
    int irq_cnt [3];
    always #25 clk_sys = ~clk_sys;
    hfd_top hfd_top_inst (.clk_sys, .rst_n, .ce, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .sensor_pin, .comparator_out, .timer_cmpa_match,
        .timer_run_bit, .timer_hw_own, .commutation_entry, .edge_irq, .filtered_sensor);
    hfd_hall_model #(.DLY(20)) hfd_hall_model_inst (.clk_sys, .timer_run_bit, .sensor_pin,
        .comparator_out, .timer_cmpa_match);
    always @(posedge clk_sys) begin
        for (int i = 0; i < 3; i++) begin
            if (edge_irq[i] === 1'b1) irq_cnt[i]++;
        end
    end
    function automatic logic [2:0] mp(input logic [2:0] c);
        return {c[0], c[1], c[2]};
    endfunction : mp
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic hall(input logic [2:0] p, input logic [2:0] c);
        hfd_hall_model_inst.drive(p, c);
        repeat (6) @(posedge clk_sys);
    endtask : hall
    task automatic t_reset();
        chk(32'(commutation_entry), 0, "entry in reset");
        apb(1'b0, OFS_CTRL, 0);
        chk(rd, 32'h0000_0010, "control reset");
        apb(1'b0, 8'h18, 0);
        chk(32'(er), 1, "unmapped error");
        $display("Test reset done");
    endtask : t_reset
    task automatic t_decode();
        for (int n = 0; n < 12; n++) apb(1'b1, OFS_TBL + 8'(4 * n), 32'(n + 1));
        for (int g = 0; g < 2; g++) begin
            for (int dr = 0; dr < 2; dr++) begin
                apb(1'b1, OFS_CTRL, 32'(g * 16 + 9 + dr * 2));
                for (int i = 0; i < 6; i++) begin
                    hall(mp(SEQ[g][i]), 3'h0);
                    chk(32'(filtered_sensor), 32'(mp(SEQ[g][i])), "bypass");
                    chk(32'(commutation_entry), 32'(dr * 6 + i + 1), "table");
                end
                for (int k = 0; k < 2; k++) begin
                    hall(mp(INV[g][k]), 3'h0);
                    chk(32'(commutation_entry), 0, "invalid");
                end
            end
        end
        apb(1'b1, OFS_CTRL, 32'h0000_001D);
        repeat (2) @(posedge clk_sys);
        chk(32'(commutation_entry), 32'(DRV_BRAKE), "brake");
        apb(1'b1, OFS_CTRL, 32'h0000_0018);
        hall(mp(3'h4), 3'h0);
        chk(32'(commutation_entry), 0, "disabled");
        apb(1'b1, OFS_EDGE, 32'h0000_0040);
        apb(1'b1, OFS_CTRL, 32'h0000_0019);
        hall(mp(3'h7), mp(3'h6));
        chk(32'(commutation_entry), 2, "comparator");
        apb(1'b1, OFS_SOFT, 32'(mp(3'h3)));
        apb(1'b1, OFS_CTRL, 32'h0000_0011);
        repeat (4) @(posedge clk_sys);
        chk(32'(commutation_entry), 4, "soft hall");
        apb(1'b1, OFS_EDGE, 0);
        $display("Test decode done");
    endtask : t_decode
    task automatic t_edge();
        for (int ch = 0; ch < 3; ch++) begin
            for (int m = 0; m < 4; m++) begin
                hall(3'h0, 3'h0);
                apb(1'b1, OFS_EDGE, 32'(m << (2 * ch)));
                irq_cnt[ch] = 0;
                hall(3'(1 << ch), 3'h0);
                hall(3'h0, 3'h0);
                chk(32'(irq_cnt[ch]), (m == 3) ? 2 : 32'(m != 0), "edges");
            end
        end
        ce <= 1'b0;
        hall(3'h7, 3'h0);
        chk(32'(filtered_sensor), 0, "frozen");
        ce <= 1'b1;
        hall(3'h7, 3'h0);
        chk(32'(filtered_sensor), 7, "resumed");
        $display("Test edge done");
    endtask : t_edge
    task automatic t_filter();
        apb(1'b1, OFS_FCNT, 3);
        apb(1'b1, OFS_FMODE, 32'h0000_0008);
        hfd_hall_model_inst.drive(3'h7, 3'h0);
        repeat (2) @(posedge clk_sys);
        hall(3'h0, 3'h0);
        repeat (12) @(posedge clk_sys);
        chk(32'(filtered_sensor), 0, "glitch");
        apb(1'b1, OFS_FMODE, 32'h0000_000A);
        hfd_hall_model_inst.drive(3'h7, 3'h0);
        repeat (12) @(posedge clk_sys);
        chk(32'(filtered_sensor), 0, "slow rate");
        repeat (40) @(posedge clk_sys);
        chk(32'(filtered_sensor), 7, "accepted");
        apb(1'b1, OFS_FCNT, 0);
        apb(1'b1, OFS_FMODE, 32'h0000_0008);
        hall(3'h0, 3'h0);
        chk(32'(filtered_sensor), 0, "fast accept");
        apb(1'b1, OFS_FMODE, 0);
        $display("Test filter done");
    endtask : t_filter
    task automatic t_delay();
        apb(1'b1, OFS_CTRL, 32'h0000_0019);
        hall(mp(3'h4), 3'h0);
        chk(32'(timer_hw_own), 0, "no owner");
        apb(1'b1, OFS_CTRL, 32'h0000_0078);
        apb(1'b1, OFS_CTRL, 32'h0000_0079);
        repeat (2) @(posedge clk_sys);
        chk(32'(timer_hw_own), 2, "owner");
        chk(32'(commutation_entry), 0, "buffer empty");
        hall(mp(3'h6), 3'h0);
        chk(32'(timer_run_bit), 2, "run");
        repeat (30) @(posedge clk_sys);
        chk(32'(commutation_entry), 2, "delayed");
        chk(32'(timer_run_bit), 0, "stopped");
        apb(1'b1, OFS_CTRL, 32'h0000_0019);
        repeat (3) @(posedge clk_sys);
        apb(1'b1, OFS_CTRL, 32'h0000_0079);
        apb(1'b0, OFS_STAT, 0);
        chk(rd & 32'h0000_0038, 0, "buffers");
        chk(32'(commutation_entry), 0, "cleared entry");
        $display("Test delay done");
    endtask : t_delay
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_reset();
        t_decode();
        t_edge();
        t_filter();
        t_delay();
        end_of_test();
    end
endmodule : tb_hall_filter_delay_commutation
`default_nettype wire
